// ### mmg_switch.v
`timescale 1ns/1ns
module mmg_switch #(
   parameter NAX  = 4,
   parameter NGRP = 2,
   parameter NMEM = 4,
   parameter TW   = 16
) (
   // apb
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   // axis feedback from drives
   input  wire [NAX-1:0] axis_online,
   input  wire [NAX-1:0] axis_moving,
   input  wire [2*NAX-1:0] axis_unit,
   input  wire [NAX-1:0] torque_zero,
   // axis drive outputs for the selected axis, then per-group stop and run outputs and one group_interp shared by all groups
   output reg  [1:0]    drive_mode,
   output reg  [TW-1:0] drive_target,
   output reg           drive_ramp_to_zero,
   output reg           drive_halt,
   output reg           drive_stop,
   output reg  [NGRP-1:0] group_stop,
   output reg  [NGRP-1:0] group_run,
   output reg  [1:0]    group_interp
);
`include "mmg_consts.vh"
   localparam AW = 2;
   localparam GW = 1;
   localparam IW = 2;
   localparam S_IDLE = 2'h0;
   localparam S_BUSY = 2'h1;
   localparam S_WAIT = 2'h2;

   // command register: [3:0] code, [5:4] queueing_option, [31] execute
   reg [31:0]  cmd;
   reg [31:0]  arg;
   reg         exec_d;
   reg [1:0]   st;
   reg         done;
   reg         busy;
   reg         err;
   reg [15:0]  fault_code;
   reg [1:0]   mode [0:NAX-1];
   reg [1:0]   pend_mode [0:NAX-1];
   reg [NAX-1:0] ramping;
   reg [1:0]   gstate [0:NGRP-1];
   reg [NMEM-1:0] mem_used [0:NGRP-1];
   reg [AW-1:0] mem_axis [0:NGRP*NMEM-1];

   wire [3:0]      code = cmd[3:0];
   wire [1:0]      queueing_option = cmd[5:4];
   wire            exec_rise = cmd[31] & ~exec_d;
   wire [AW-1:0]   ax = arg[AW-1:0];
   wire [GW-1:0]   group_select = arg[GW+3:4];
   wire [IW-1:0]   member_index = arg[IW+7:8];
   wire [1:0]      ip_kind = arg[13:12];
   wire            pos_cmd = (code == `MMG_CMD_ABS) | (code == `MMG_CMD_REL)
                              | (code == `MMG_CMD_ADD);
   wire            apb_wr = psel & penable & pwrite & ~pready;
   wire            apb_rd = psel & penable & ~pwrite & ~pready;

   // per-group membership checks, one combinational always block
   reg  [NGRP-1:0] g_empty, g_offline, g_moving, g_units, g_shared;
   integer gi, mi, oj, ok;
   reg  [AW-1:0]   a0, am;
   always @* begin
      for (gi = 0; gi < NGRP; gi = gi + 1) begin
         g_empty[gi] = ~|mem_used[gi];
         g_offline[gi] = 1'b0;
         g_moving[gi] = 1'b0;
         g_units[gi] = 1'b0;
         g_shared[gi] = 1'b0;
         a0 = {AW{1'b0}};
         for (mi = NMEM - 1; mi >= 0; mi = mi - 1) begin
            if (mem_used[gi][mi])
               a0 = mem_axis[gi*NMEM+mi];
         end
         for (mi = 0; mi < NMEM; mi = mi + 1) begin
            am = mem_axis[gi*NMEM+mi];
            if (mem_used[gi][mi]) begin
               if (!axis_online[am])
                  g_offline[gi] = 1'b1;
               if (axis_moving[am])
                  g_moving[gi] = 1'b1;
               if (axis_unit[2*am +: 2] != axis_unit[2*a0 +: 2])
                  g_units[gi] = 1'b1;
               for (oj = 0; oj < NGRP; oj = oj + 1) begin
                  for (ok = 0; ok < NMEM; ok = ok + 1) begin
                     if (oj != gi && gstate[oj] != `MMG_G_OFF
                         && mem_used[oj][ok]
                         && mem_axis[oj*NMEM+ok] == am)
                        g_shared[gi] = 1'b1;
                  end
               end
            end
         end
      end
   end

   wire [1:0]  gs = gstate[group_select];
   wire [NMEM-1:0] used = mem_used[group_select];

   // command checking, returns fault code or none
   reg [15:0] chk;
   always @* begin
      chk = `MMG_F_NONE;
      case (code)
         `MMG_CMD_VEL, `MMG_CMD_ABS, `MMG_CMD_REL, `MMG_CMD_ADD,
         `MMG_CMD_TRQ, `MMG_CMD_HALT, `MMG_CMD_STOP:
            chk = `MMG_F_NONE;
         `MMG_CMD_INSERT, `MMG_CMD_DROP: begin
            if (gs == `MMG_G_MOVE)
               chk = `MMG_F_GSTATE;
            else if (code == `MMG_CMD_DROP && !used[member_index])
               chk = `MMG_F_BADIDX;
         end
         `MMG_CMD_DROPALL:
            chk = (gs == `MMG_G_MOVE) ? `MMG_F_GSTATE : `MMG_F_NONE;
         `MMG_CMD_GON: begin
            if (g_empty[group_select] || g_offline[group_select])
               chk = `MMG_F_EMPTY;
            else if (g_shared[group_select])
               chk = `MMG_F_SHARED;
            else if (g_moving[group_select])
               chk = `MMG_F_MOVING;
            else if (g_units[group_select])
               chk = `MMG_F_UNITS;
         end
         `MMG_CMD_GOFF:
            chk = `MMG_F_NONE;
         `MMG_CMD_GMOVE: begin
            if (gs != `MMG_G_IDLE)
               chk = `MMG_F_NOTENABLED;
            else if (ip_kind == 2'h3)
               chk = `MMG_F_BADIP;
         end
         default:
            chk = `MMG_F_BADCMD;
      endcase
   end

   // axis mode engine, one generate loop
   genvar ga;
   generate
      for (ga = 0; ga < NAX; ga = ga + 1) begin : g_axis
         wire take = (st == S_BUSY) && (chk == `MMG_F_NONE) && (ax == ga)
                     && (queueing_option == `MMG_Q_ABORT);
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mode[ga] <= `MMG_MODE_IDLE;
               pend_mode[ga] <= `MMG_MODE_IDLE;
               ramping[ga] <= 1'b0;
            end else if (take && (code == `MMG_CMD_HALT
                                  || code == `MMG_CMD_STOP)) begin
               mode[ga] <= `MMG_MODE_IDLE;
               ramping[ga] <= 1'b0;
            end else if (take && code == `MMG_CMD_VEL) begin
               if (mode[ga] == `MMG_MODE_TRQ) begin
                  ramping[ga] <= 1'b1;
                  pend_mode[ga] <= `MMG_MODE_VEL;
               end else begin
                  mode[ga] <= `MMG_MODE_VEL;
                  ramping[ga] <= 1'b0;
               end
            end else if (take && pos_cmd) begin
               if (mode[ga] == `MMG_MODE_TRQ) begin
                  ramping[ga] <= 1'b1;
                  pend_mode[ga] <= `MMG_MODE_POS;
               end else begin
                  mode[ga] <= `MMG_MODE_POS;
                  ramping[ga] <= 1'b0;
               end
            end else if (take && code == `MMG_CMD_TRQ) begin
               mode[ga] <= `MMG_MODE_TRQ;
               ramping[ga] <= 1'b0;
            end else if (ramping[ga] && torque_zero[ga]) begin
               mode[ga] <= pend_mode[ga];
               ramping[ga] <= 1'b0;
            end
         end
      end
   endgenerate

   // command sequencer and group state
   integer k;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_d <= 1'b0;
         st <= S_IDLE;
         done <= 1'b0;
         busy <= 1'b0;
         err <= 1'b0;
         fault_code <= `MMG_F_NONE;
         for (k = 0; k < NGRP; k = k + 1) begin
            gstate[k] <= `MMG_G_OFF;
            mem_used[k] <= {NMEM{1'b0}};
         end
         for (k = 0; k < NGRP*NMEM; k = k + 1)
            mem_axis[k] <= {AW{1'b0}};
         group_stop <= {NGRP{1'b0}};
         group_run <= {NGRP{1'b0}};
         group_interp <= `MMG_IP_LINEAR;
      end else begin
         exec_d <= cmd[31];
         group_stop <= {NGRP{1'b0}};
         for (k = 0; k < NGRP; k = k + 1) begin
            if (gstate[k] == `MMG_G_MOVE && !g_moving[k] && !group_run[k])
               gstate[k] <= `MMG_G_IDLE;
            group_run[k] <= 1'b0;
         end
         case (st)
            S_IDLE: begin
               if (exec_rise) begin
                  st <= S_BUSY;
                  busy <= 1'b1;
                  done <= 1'b0;
                  err <= 1'b0;
                  fault_code <= `MMG_F_NONE;
               end
            end
            S_BUSY: begin
               st <= S_WAIT;
               busy <= 1'b0;
               if (chk != `MMG_F_NONE) begin
                  err <= 1'b1;
                  fault_code <= chk;
               end else begin
                  done <= 1'b1;
                  case (code)
                     `MMG_CMD_INSERT: begin
                        mem_used[group_select][member_index] <= 1'b1;
                        mem_axis[group_select*NMEM+member_index] <= ax;
                     end
                     `MMG_CMD_DROP: begin
                        mem_used[group_select][member_index] <= 1'b0;
                        if ((used & ~({{(NMEM-1){1'b0}}, 1'b1}
                                     << member_index)) == {NMEM{1'b0}})
                           gstate[group_select] <= `MMG_G_OFF;
                     end
                     `MMG_CMD_DROPALL: begin
                        mem_used[group_select] <= {NMEM{1'b0}};
                        gstate[group_select] <= `MMG_G_OFF;
                     end
                     `MMG_CMD_GON:
                        gstate[group_select] <= `MMG_G_IDLE;
                     `MMG_CMD_GOFF: begin
                        if (gs == `MMG_G_MOVE)
                           group_stop[group_select] <= 1'b1;
                        gstate[group_select] <= `MMG_G_OFF;
                     end
                     `MMG_CMD_GMOVE: begin
                        gstate[group_select] <= `MMG_G_MOVE;
                        group_run[group_select] <= 1'b1;
                        group_interp <= ip_kind;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            S_WAIT: begin
               if (!cmd[31])
                  st <= S_IDLE;
            end
            default:
               st <= S_IDLE;
         endcase
      end
   end

   // drive outputs for the axis named in arg
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_mode <= `MMG_MODE_IDLE;
         drive_target <= {TW{1'b0}};
         drive_ramp_to_zero <= 1'b0;
         drive_halt <= 1'b0;
         drive_stop <= 1'b0;
      end else begin
         drive_mode <= mode[ax];
         drive_ramp_to_zero <= ramping[ax];
         // target follows arg; drive ramps from its present value
         drive_target <= arg[31:32-TW];
         drive_halt <= (st == S_BUSY) && (code == `MMG_CMD_HALT);
         drive_stop <= (st == S_BUSY) && (code == `MMG_CMD_STOP);
      end
   end

   // apb slave, one wait state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd <= 32'h00000000;
         arg <= 32'h00000000;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= 1'b0;
         if (apb_wr) begin
            if (paddr == `MMG_OFF_CMD)
               cmd <= pwdata;
            else if (paddr == `MMG_OFF_ARG)
               arg <= pwdata;
            else
               pslverr <= 1'b1;
         end
         if (apb_rd) begin
            case (paddr)
               `MMG_OFF_CMD:    prdata <= cmd;
               `MMG_OFF_ARG:    prdata <= arg;
               `MMG_OFF_STATUS: prdata <= {29'h0, err, busy, done};
               `MMG_OFF_FAULT:  prdata <= {16'h0000, fault_code};
               `MMG_OFF_AXIS:   prdata <= {29'h0, ramping[ax], mode[ax]};
               `MMG_OFF_GROUP:  prdata <= {{(32-NMEM-2){1'b0}}, used, gs};
               default: begin
                  prdata <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule

// ### mmg_consts.vh
`ifndef MMG_CONSTS_VH
`define MMG_CONSTS_VH
// register byte offsets
`define MMG_OFF_CMD      12'h000
`define MMG_OFF_ARG      12'h004
`define MMG_OFF_STATUS   12'h008
`define MMG_OFF_FAULT    12'h00c
`define MMG_OFF_AXIS     12'h010
`define MMG_OFF_GROUP    12'h014
// command codes, low nibble of cmd register
`define MMG_CMD_NONE     4'h0
`define MMG_CMD_VEL      4'h1
`define MMG_CMD_ABS      4'h2
`define MMG_CMD_REL      4'h3
`define MMG_CMD_ADD      4'h4
`define MMG_CMD_TRQ      4'h5
`define MMG_CMD_HALT     4'h6
`define MMG_CMD_STOP     4'h7
`define MMG_CMD_INSERT   4'h8
`define MMG_CMD_DROP     4'h9
`define MMG_CMD_DROPALL  4'ha
`define MMG_CMD_GON      4'hb
`define MMG_CMD_GOFF     4'hc
`define MMG_CMD_GMOVE    4'hd
// queueing option, cmd bits 5:4
`define MMG_Q_ABORT      2'h0
// axis control modes
`define MMG_MODE_IDLE    2'h0
`define MMG_MODE_POS     2'h1
`define MMG_MODE_VEL     2'h2
`define MMG_MODE_TRQ     2'h3
// group states
`define MMG_G_OFF        2'h0
`define MMG_G_IDLE       2'h1
`define MMG_G_MOVE       2'h2
// interpolation kinds, arg bits 13:12
`define MMG_IP_LINEAR    2'h0
`define MMG_IP_CIRCULAR  2'h1
`define MMG_IP_HELICAL   2'h2
// fault codes
`define MMG_F_NONE       16'h0000
`define MMG_F_BADCMD     16'h1001
`define MMG_F_NOTENABLED 16'h1002
`define MMG_F_GSTATE     16'h1003
`define MMG_F_EMPTY      16'h1004
`define MMG_F_OFFLINE    16'h1005
`define MMG_F_SHARED     16'h1006
`define MMG_F_MOVING     16'h1007
`define MMG_F_UNITS      16'h1008
`define MMG_F_BADIDX     16'h1009
`define MMG_F_BADIP      16'h100a
`endif

// ### mmg_switch_properties.sv
`timescale 1ns/1ns
`include "mmg_consts.vh"
module mmg_switch_checker #(
   parameter NGRP = 2
) (
   input wire            pclk,
   input wire            presetn,
   input wire            psel,
   input wire            penable,
   input wire            pready,
   input wire            pslverr,
   input wire [1:0]      drive_mode,
   input wire            drive_ramp_to_zero,
   input wire            drive_halt,
   input wire            drive_stop,
   input wire [NGRP-1:0] group_stop,
   input wire [NGRP-1:0] group_run,
   input wire [1:0]      group_interp
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   property p_wait;
      s_access |=> s_answer;
   endproperty
   a_wait: assert property (p_wait) else $error("late bus answer");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("stray bus error");
   property p_origin;
      pready |-> $past(psel && penable);
   endproperty
   a_origin: assert property (p_origin) else $error("unasked answer");
   property p_halt;
      drive_halt |=> !drive_halt;
   endproperty
   a_halt: assert property (p_halt) else $error("halt not a pulse");
   property p_stop;
      drive_stop |=> !drive_stop;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not a pulse");
   property p_run;
      (|group_run) |=> (group_run == {NGRP{1'b0}});
   endproperty
   a_run: assert property (p_run) else $error("run not a pulse");
   property p_gstop;
      (|group_stop) |-> !(|group_run) ##1 (group_stop == {NGRP{1'b0}});
   endproperty
   a_gstop: assert property (p_gstop) else $error("bad group stop");
   property p_interp;
      (|group_run) |-> (group_interp != 2'h3);
   endproperty
   a_interp: assert property (p_interp) else $error("bad interp");
   property p_ramp;
      drive_ramp_to_zero |-> (drive_mode == `MMG_MODE_TRQ);
   endproperty
   a_ramp: assert property (p_ramp) else $error("mode left early");
endmodule
bind mmg_switch mmg_switch_checker #(.NGRP(NGRP)) mmg_switch_checker_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .drive_mode(drive_mode),
   .drive_ramp_to_zero(drive_ramp_to_zero), .drive_halt(drive_halt),
   .drive_stop(drive_stop), .group_stop(group_stop),
   .group_run(group_run), .group_interp(group_interp));

// ### mmg_drives.sv
`timescale 1ns/1ns
module mmg_drives #(
   parameter NAX = 4,
   parameter DLY = 60
) (
   input  wire           pclk,
   input  wire           presetn,
   input  wire           drive_ramp_to_zero,
   output reg  [NAX-1:0] torque_zero
);
   reg [7:0] ramp_cnt;
   // torque reaches zero DLY+1 cycles into the ramp, never at once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_cnt    <= 8'h00;
         torque_zero <= {NAX{1'b0}};
      end else if (!drive_ramp_to_zero) begin
         ramp_cnt    <= 8'h00;
         torque_zero <= {NAX{1'b0}};
      end else begin
         if (ramp_cnt != DLY[7:0]) ramp_cnt <= ramp_cnt + 8'h01;
         torque_zero <= {NAX{ramp_cnt == DLY[7:0]}};
      end
   end
endmodule

// ### mmg_switch_bench.sv
`timescale 1ns/1ns
`include "mmg_consts.vh"
module mmg_switch_bench;
   reg         pclk;
   reg         presetn;
   reg         psel;
   reg         penable;
   reg         pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   reg  [3:0]  axis_online;
   reg  [3:0]  axis_moving;
   reg  [7:0]  axis_unit;
   wire [3:0]  torque_zero;
   wire [1:0]  drive_mode;
   wire [15:0] drive_target;
   wire        drive_ramp_to_zero;
   wire        drive_halt;
   wire        drive_stop;
   wire [1:0]  group_stop;
   wire [1:0]  group_run;
   wire [1:0]  group_interp;
   reg  [31:0] rdata;
   reg         rerr;
   integer     bad_count;
   integer     checked;
   integer     n_halt = 0;
   integer     n_stop = 0;
   integer     n_run = 0;
   integer     n_dstop = 0;
   integer     i;
   integer     c0;
   mmg_switch #(.NAX(4), .NGRP(2)) mmg_switch_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .axis_online(axis_online),
      .axis_moving(axis_moving), .axis_unit(axis_unit),
      .torque_zero(torque_zero), .drive_mode(drive_mode),
      .drive_target(drive_target), .drive_ramp_to_zero(drive_ramp_to_zero),
      .drive_halt(drive_halt), .drive_stop(drive_stop),
      .group_stop(group_stop), .group_run(group_run),
      .group_interp(group_interp));
   mmg_drives #(.NAX(4), .DLY(60)) mmg_drives_inst (
      .pclk(pclk), .presetn(presetn),
      .drive_ramp_to_zero(drive_ramp_to_zero), .torque_zero(torque_zero));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (drive_halt === 1'b1) n_halt <= n_halt + 1;
      if (drive_stop === 1'b1) n_dstop <= n_dstop + 1;
      if (group_stop[0] === 1'b1) n_stop <= n_stop + 1;
      if (|group_run === 1'b1) n_run <= n_run + 1;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task xfer(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         // no cycle limit here: only the watchdog ends a hung wait
         while (pready !== 1'b1)
            @(posedge pclk);
         rdata = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rd(input [11:0] a, input [31:0] exp);
      begin
         xfer(1'b0, a, 32'h0);
         chk(rdata, exp);
      end
   endtask
   function [31:0] arg(input [1:0] ax, input g, input [1:0] ix,
                       input [1:0] ip);
      arg = {16'h0123, 2'h0, ip, 2'h0, ix, 3'h0, g, 2'h0, ax};
   endfunction
   // only aborting queueing makes a switch happen; other options leave the mode as it is
   task run(input [3:0] code, input [1:0] q, input [31:0] a,
            input [15:0] flt);
      integer n;
      begin
         n = 0;
         xfer(1'b1, `MMG_OFF_ARG, a);
         xfer(1'b1, `MMG_OFF_CMD, {1'b1, 25'h0, q, code});
         rdata = 32'h0;
         while (rdata[0] !== 1'b1 && rdata[2] !== 1'b1 && n < 20) begin
            xfer(1'b0, `MMG_OFF_STATUS, 32'h0);
            n = n + 1;
         end
         chk(rdata & 32'h7, flt == 16'h0 ? 32'h1 : 32'h4);
         rd(`MMG_OFF_FAULT, {16'h0, flt});
         xfer(1'b1, `MMG_OFF_CMD, 32'h0);
      end
   endtask
   task wait_mode(input [1:0] m);
      begin
         rdata = 32'h4;
         for (i = 0; i < 40 && rdata[2] !== 1'b0; i = i + 1)
            xfer(1'b0, `MMG_OFF_AXIS, 32'h0);
         chk(rdata, {30'h0, m});
      end
   endtask
   task t_regs;
      begin
         rd(`MMG_OFF_STATUS, 32'h0);
         rd(`MMG_OFF_AXIS, 32'h0);
         rd(`MMG_OFF_GROUP, 32'h0);
         xfer(1'b0, 12'h018, 32'h0);
         chk({31'h0, rerr}, 32'h1);
         xfer(1'b1, `MMG_OFF_STATUS, 32'h7);
         chk({31'h0, rerr}, 32'h1);
         run(4'he, 2'h0, 32'h0, `MMG_F_BADCMD);
         $display("t_regs done");
      end
   endtask
   task t_modes;
      begin
         for (c0 = 2; c0 < 5; c0 = c0 + 1) begin
            run(`MMG_CMD_VEL, `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
            rd(`MMG_OFF_AXIS, 32'h2);
            run(c0[3:0], `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
            rd(`MMG_OFF_AXIS, 32'h1);
         end
         chk({30'h0, drive_mode}, 32'h1);
         chk({16'h0, drive_target}, 32'h0123);
         run(`MMG_CMD_TRQ, `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
         rd(`MMG_OFF_AXIS, 32'h3);
         run(`MMG_CMD_ABS, `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
         rd(`MMG_OFF_AXIS, 32'h7);
         chk({31'h0, drive_ramp_to_zero}, 32'h1);
         wait_mode(`MMG_MODE_POS);
         chk({31'h0, drive_ramp_to_zero}, 32'h0);
         run(`MMG_CMD_TRQ, `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
         run(`MMG_CMD_VEL, `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
         rd(`MMG_OFF_AXIS, 32'h7);
         wait_mode(`MMG_MODE_VEL);
         run(`MMG_CMD_TRQ, `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
         rd(`MMG_OFF_AXIS, 32'h3);
         run(`MMG_CMD_VEL, 2'h1, arg(0, 0, 0, 0), 16'h0);
         rd(`MMG_OFF_AXIS, 32'h3);
         c0 = n_halt;
         run(`MMG_CMD_HALT, `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
         chk(n_halt - c0, 32'h1);
         rd(`MMG_OFF_AXIS, 32'h0);
         run(`MMG_CMD_VEL, `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
         rd(`MMG_OFF_AXIS, 32'h2);
         c0 = n_dstop;
         run(`MMG_CMD_STOP, `MMG_Q_ABORT, arg(0, 0, 0, 0), 16'h0);
         chk(n_dstop - c0, 32'h1);
         rd(`MMG_OFF_AXIS, 32'h0);
         $display("t_modes done");
      end
   endtask
   task t_group;
      begin
         run(`MMG_CMD_GMOVE, 2'h0, arg(0, 0, 0, 0), `MMG_F_NOTENABLED);
         run(`MMG_CMD_GON, 2'h0, arg(0, 0, 0, 0), `MMG_F_EMPTY);
         run(`MMG_CMD_INSERT, 2'h0, arg(0, 0, 0, 0), 16'h0);
         run(`MMG_CMD_INSERT, 2'h0, arg(1, 0, 1, 0), 16'h0);
         rd(`MMG_OFF_GROUP, {26'h0, 4'h3, `MMG_G_OFF});
         axis_unit <= 8'h04;
         run(`MMG_CMD_GON, 2'h0, arg(0, 0, 0, 0), `MMG_F_UNITS);
         axis_unit <= 8'h00;
         axis_moving <= 4'h2;
         run(`MMG_CMD_GON, 2'h0, arg(0, 0, 0, 0), `MMG_F_MOVING);
         axis_moving <= 4'h0;
         axis_online <= 4'he;
         run(`MMG_CMD_GON, 2'h0, arg(0, 0, 0, 0), `MMG_F_EMPTY);
         axis_online <= 4'hf;
         run(`MMG_CMD_GON, 2'h0, arg(0, 0, 0, 0), 16'h0);
         rd(`MMG_OFF_GROUP, {26'h0, 4'h3, `MMG_G_IDLE});
         run(`MMG_CMD_INSERT, 2'h0, arg(1, 1, 0, 0), 16'h0);
         run(`MMG_CMD_GON, 2'h0, arg(0, 1, 0, 0), `MMG_F_SHARED);
         run(`MMG_CMD_DROPALL, 2'h0, arg(0, 1, 0, 0), 16'h0);
         rd(`MMG_OFF_GROUP, {26'h0, 4'h0, `MMG_G_OFF});
         for (c0 = 0; c0 < 3; c0 = c0 + 1) begin
            i = n_run;
            run(`MMG_CMD_GMOVE, 2'h0, arg(0, 0, 0, c0[1:0]), 16'h0);
            chk(n_run - i, 32'h1);
            chk({30'h0, group_interp}, c0);
         end
         run(`MMG_CMD_GMOVE, 2'h0, arg(0, 0, 0, 3), `MMG_F_BADIP);
         axis_moving <= 4'h1;
         run(`MMG_CMD_GMOVE, 2'h0, arg(0, 0, 0, 0), 16'h0);
         rd(`MMG_OFF_GROUP, {26'h0, 4'h3, `MMG_G_MOVE});
         run(`MMG_CMD_INSERT, 2'h0, arg(2, 0, 2, 0), `MMG_F_GSTATE);
         run(`MMG_CMD_DROP, 2'h0, arg(0, 0, 1, 0), `MMG_F_GSTATE);
         c0 = n_stop;
         run(`MMG_CMD_GOFF, 2'h0, arg(0, 0, 0, 0), 16'h0);
         chk(n_stop - c0, 32'h1);
         rd(`MMG_OFF_GROUP, {26'h0, 4'h3, `MMG_G_OFF});
         axis_moving <= 4'h0;
         run(`MMG_CMD_GON, 2'h0, arg(0, 0, 0, 0), 16'h0);
         run(`MMG_CMD_DROP, 2'h0, arg(0, 0, 1, 0), 16'h0);
         rd(`MMG_OFF_GROUP, {26'h0, 4'h1, `MMG_G_IDLE});
         run(`MMG_CMD_DROP, 2'h0, arg(0, 0, 0, 0), 16'h0);
         rd(`MMG_OFF_GROUP, {26'h0, 4'h0, `MMG_G_OFF});
         run(`MMG_CMD_DROP, 2'h0, arg(0, 0, 0, 0), `MMG_F_BADIDX);
         $display("t_group done");
      end
   endtask
   task print_verdict;
      begin
         $display("checks=%0d mismatches=%0d", checked, bad_count);
         if (bad_count == 0 && checked > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #400000;
      bad_count = bad_count + 1;
      print_verdict;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      axis_online = 4'hf;
      axis_moving = 4'h0;
      axis_unit = 8'h00;
      bad_count = 0;
      checked = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_modes;
      t_group;
      print_verdict;
   end
endmodule
